// file: include/dtt_consts.svh
/*
  Constants for the delayed transaction target: command codes, field widths,
  completion status codes and the discard timer length.
  Assumes inclusion by the package and the design files through its bare name.
*/
// Function
// R01: IACK, I/O read/write, config read/write and memory reads may be delayed.
// R02: Memory write and write-and-invalidate are posted or retried, never delayed.
// R03: A new delayable access is decoded, captured and answered with Retry.
// R04: A retried master keeps reissuing the request until it completes.
// R05: The captured request runs on the destination side on the block's initiative.
// R06: Completion keeps request fields, status and read data until collected.
// R07: A matching repeat gets exactly the recorded status and data, then retires.
// R08: Capture address, command, byte enables, wide flag; parity only when enabled.
// R09: Delayed write data is captured from every enabled byte lane.
// R10: Write data is sampled only with IRDY; byte enables any time.
// R11: Compare each access with stored entry; prefetchable reads may skip enables.
// R12: A repeat of a queued, uncompleted request is retried, not queued again.
// R13: The master repeats identically, all lanes, else it counts as new.
// R14: Masters are not tracked; any identical request collects the completion.
// R15: A request may be dropped until attempted, never after the first attempt.
// R16: Every attempted request is repeated fairly until it completes.
// R17: Early drop only for prefetchable reads or read-line/read-multiple completions.
// R18: A discard timer drops any completion uncollected after 2^15 clocks.
// R19: Error report on expiry for non-prefetchable reads only.
// R20: Memory writes stay accepted while a delayed request is outstanding.
// R21: Memory write acceptance never waits for collection of a completion.
// R22: A single-source master drops its request two clocks before a retry.
// R23: The single entry retries any non-matching delayable request while occupied.
// R24: The discard timer runs from storing a completion until its retirement.
`ifndef DTT_CONSTS_SVH
`define DTT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths and command codes
// ----------------------------------------------------------------------------
`define DTT_AW            32
`define DTT_DW            32
`define DTT_NBE           4
`define DTT_CMD_IACK      4'h0
`define DTT_CMD_IO_RD     4'h2
`define DTT_CMD_IO_WR     4'h3
`define DTT_CMD_MEM_RD    4'h6
`define DTT_CMD_MEM_WR    4'h7
`define DTT_CMD_CFG_RD    4'hA
`define DTT_CMD_CFG_WR    4'hB
`define DTT_CMD_MEM_RDM   4'hC
`define DTT_CMD_MEM_RDL   4'hE
`define DTT_CMD_MEM_WRI   4'hF

// ----------------------------------------------------------------------------
// Completion status codes and discard timer
// ----------------------------------------------------------------------------
`define DTT_ST_NORMAL     3'h0
`define DTT_ST_MABORT     3'h1
`define DTT_ST_TABORT     3'h2
`define DTT_ST_PARERR     3'h3
`define DTT_ST_DISC       3'h4
`define DTT_DISCARD_CLKS  32768
`define DTT_TMR_W         16

`endif

// file: include/dtt_pkg.sv
/*
  Types of the delayed transaction target: entry states, answer codes and the
  packed state of the main module.
  Assumes dtt_consts.svh on the include path.
*/
`default_nettype none
`include "dtt_consts.svh"

package dtt_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_QUEUED, ST_ATTEMPT, ST_DONE} dtt_state_e;

  // Answer to the access on the originating side
  typedef enum logic [1:0] {RSP_NONE, RSP_RETRY, RSP_COMPLETE, RSP_POSTED} dtt_rsp_e;

  typedef struct packed {
    dtt_state_e                state;
    logic [3:0]                cmd;
    logic [`DTT_AW-1:0]        addr;
    logic [`DTT_NBE-1:0]       be;
    logic                      req64;
    logic                      par;
    logic                      pref;
    logic [`DTT_DW-1:0]        wdata;
    logic [2:0]                status;
    logic [`DTT_DW-1:0]        rdata;
    logic                      disc_err;
  } dtt_regs_s;

endpackage : dtt_pkg

`default_nettype wire

// file: rtl/dtt_discard_timer.sv
/*
  Discard timer for the single stored completion.
  Assumes run is high exactly while a completion is held; dropping run clears it.
*/
`default_nettype none
`include "dtt_consts.svh"

module dtt_discard_timer
  import dtt_pkg::*;
#(
  parameter int unsigned LIMIT = `DTT_DISCARD_CLKS
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      expired
);

  typedef struct packed {
    logic [`DTT_TMR_W-1:0] cnt;
  } dtt_tmr_s;

  dtt_tmr_s tmr;
  dtt_tmr_s next_tmr;

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  // Counts only while a completion is held, restarts from zero otherwise
  always_comb begin
    next_tmr = tmr;
    next_tmr.cnt = run ? tmr.cnt + `DTT_TMR_W'(1) : '0; // R24
  end

  // Pulse on the last allowed clock so the owner drops the entry on time
  assign expired = run && (tmr.cnt == `DTT_TMR_W'(LIMIT - 1)); // R18

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tmr <= '0;
    end else begin
      tmr <= next_tmr;
    end
  end

endmodule : dtt_discard_timer

`default_nettype wire

// file: rtl/dtt_target.sv
/*
  Delayed transaction target with a single request/completion entry.
  Assumes the originating master holds an access steady until answered and that
  the posted write sink and the destination side run on ref_clk.
*/
`default_nettype none
`include "dtt_consts.svh"

module dtt_target
  import dtt_pkg::*;
#(
  parameter int unsigned DISCARD_CLKS = `DTT_DISCARD_CLKS
) (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                par_resp_en,
  input  wire logic                acc_valid,
  input  wire logic                acc_irdy,
  input  wire logic [3:0]          acc_cmd,
  input  wire logic [`DTT_AW-1:0]  acc_addr,
  input  wire logic [`DTT_NBE-1:0] acc_be,
  input  wire logic                acc_req64,
  input  wire logic                acc_par,
  input  wire logic                acc_pref,
  input  wire logic [`DTT_DW-1:0]  acc_wdata,
  output dtt_rsp_e                 rsp,
  output logic [2:0]               rsp_status,
  output logic [`DTT_DW-1:0]       rsp_rdata,
  output logic                     pw_valid,
  input  wire logic                pw_ready,
  input  wire logic                dst_ready,
  output logic                     dst_req,
  output logic [3:0]               dst_cmd,
  output logic [`DTT_AW-1:0]       dst_addr,
  output logic [`DTT_NBE-1:0]      dst_be,
  output logic                     dst_req64,
  output logic [`DTT_DW-1:0]       dst_wdata,
  input  wire logic                dst_done,
  input  wire logic [2:0]          dst_status,
  input  wire logic [`DTT_DW-1:0]  dst_rdata,
  output logic                     disc_err
);

  // ----------------------------------------------------------------------------
  // Command decoding
  // ----------------------------------------------------------------------------
  function automatic logic is_delayable(input logic [3:0] c);
    return c inside {`DTT_CMD_IACK, `DTT_CMD_IO_RD, `DTT_CMD_IO_WR, `DTT_CMD_CFG_RD,
                     `DTT_CMD_CFG_WR, `DTT_CMD_MEM_RD, `DTT_CMD_MEM_RDL,
                     `DTT_CMD_MEM_RDM}; // R01
  endfunction : is_delayable

  function automatic logic is_mem_write(input logic [3:0] c);
    return c inside {`DTT_CMD_MEM_WR, `DTT_CMD_MEM_WRI};
  endfunction : is_mem_write

  function automatic logic is_dly_write(input logic [3:0] c);
    return c inside {`DTT_CMD_IO_WR, `DTT_CMD_CFG_WR};
  endfunction : is_dly_write

  function automatic logic is_line_read(input logic [3:0] c);
    return c inside {`DTT_CMD_MEM_RDL, `DTT_CMD_MEM_RDM};
  endfunction : is_line_read

  dtt_regs_s st;
  dtt_regs_s next_st;
  logic [`DTT_DW-1:0] lane_mask;
  logic               data_ok;
  logic               hit;
  logic               droppable;
  logic               served;
  logic               expired;

  // ----------------------------------------------------------------------------
  // Byte lane mask
  // ----------------------------------------------------------------------------
  // Only enabled lanes are kept and compared; disabled lanes read as zero
  for (genvar g = 0; g < `DTT_NBE; g++) begin : g_lane
    assign lane_mask[8*g +: 8] = {8{acc_be[g]}}; // R09
  end

  // Write data is only good with IRDY; reads need no data phase handshake
  assign data_ok = !is_dly_write(acc_cmd) && !is_mem_write(acc_cmd) || acc_irdy; // R10

  // Compare with the stored entry, any master may hit it
  always_comb begin
    hit = (st.state != ST_IDLE) && (acc_cmd == st.cmd) && (acc_addr == st.addr) // R14
          && (acc_req64 == st.req64)
          && ((acc_wdata & lane_mask) == st.wdata || !is_dly_write(acc_cmd)) // R13
          && ((acc_be == st.be) || (acc_pref && !is_dly_write(acc_cmd) && st.pref)); // R11
  end

  // A prefetchable read completion may be thrown away for a new request
  assign droppable = (st.state == ST_DONE) && (st.pref || is_line_read(st.cmd)); // R17
  assign served    = acc_valid && data_ok && hit && (st.state == ST_DONE);

  // ----------------------------------------------------------------------------
  // Entry control and access answer
  // ----------------------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.disc_err = 1'b0;
    rsp              = RSP_NONE;
    pw_valid         = 1'b0;
    unique case (st.state)
      ST_IDLE: begin
      end
      // Not yet attempted, so still free to wait for the destination
      ST_QUEUED: begin
        if (dst_ready) begin
          next_st.state = ST_ATTEMPT; // R05
        end
      end
      // Once attempted the entry stays until the destination finishes
      ST_ATTEMPT: begin
        if (dst_done) begin
          next_st.state  = ST_DONE; // R15
          next_st.status = dst_status; // R06
          next_st.rdata  = is_dly_write(st.cmd) ? '0 : dst_rdata;
        end
      end
      ST_DONE: begin
        if (expired && !served) begin
          next_st.state    = ST_IDLE; // R18
          next_st.disc_err = !is_dly_write(st.cmd) && !st.pref && !is_line_read(st.cmd); // R19
        end
      end
    endcase
    if (acc_valid && data_ok) begin
      if (is_mem_write(acc_cmd)) begin
        // Posted path ignores the entry entirely, avoiding the write deadlock
        pw_valid = 1'b1; // R02
        rsp      = pw_ready ? RSP_POSTED : RSP_RETRY; // R20 R21
      end else if (is_delayable(acc_cmd)) begin
        if (served) begin
          rsp           = RSP_COMPLETE; // R07
          next_st.state = ST_IDLE;
        end else if (st.state == ST_IDLE || (droppable && !hit)) begin
          rsp           = RSP_RETRY; // R03
          next_st.state = ST_QUEUED;
          next_st.cmd   = acc_cmd; // R08
          next_st.addr  = acc_addr;
          next_st.be    = acc_be;
          next_st.req64 = acc_req64;
          next_st.par   = par_resp_en ? acc_par : 1'b0;
          next_st.pref  = acc_pref && !is_dly_write(acc_cmd);
          next_st.wdata = is_dly_write(acc_cmd) ? (acc_wdata & lane_mask) : '0; // R09
        end else begin
          rsp = RSP_RETRY; // R12 R23
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs and discard timer
  // ----------------------------------------------------------------------------
  assign rsp_status = st.status;
  assign rsp_rdata  = st.rdata;
  assign dst_req    = (st.state == ST_ATTEMPT); // R16
  assign dst_cmd    = st.cmd;
  assign dst_addr   = st.addr;
  assign dst_be     = st.be;
  assign dst_req64  = st.req64;
  assign dst_wdata  = st.wdata;
  assign disc_err   = st.disc_err;

  dtt_discard_timer #(
    .LIMIT (DISCARD_CLKS)
  ) u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .run     (st.state == ST_DONE), // R24
    .expired (expired)
  );

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  // Age of the held completion, read only by the checks
  logic [`DTT_TMR_W:0] done_age;
  always_ff @(posedge ref_clk) begin
    if (srst || st.state != ST_DONE) begin
      done_age <= '0;
    end else begin
      done_age <= done_age + (`DTT_TMR_W+1)'(1);
    end
  end

  property p_mw_posted;
    @(posedge ref_clk) disable iff (srst)
    (acc_valid && acc_irdy && is_mem_write(acc_cmd))
      |-> pw_valid && (rsp == (pw_ready ? RSP_POSTED : RSP_RETRY))
          ##1 $stable(st.cmd) && $stable(st.addr);
  endproperty
  a_mw_posted: assert property (p_mw_posted) else $error("memory write mishandled"); // R02

  property p_capture;
    @(posedge ref_clk) disable iff (srst)
    (acc_valid && !is_mem_write(acc_cmd) && is_delayable(acc_cmd) && data_ok
     && st.state == ST_IDLE)
      |-> rsp == RSP_RETRY ##1 st.state == ST_QUEUED && st.addr == $past(acc_addr)
          && st.cmd == $past(acc_cmd);
  endproperty
  a_capture: assert property (p_capture) else $error("new request not captured"); // R03

  property p_parity;
    @(posedge ref_clk) disable iff (srst)
    ($past(st.state) != ST_QUEUED && st.state == ST_QUEUED)
      |-> st.par == ($past(par_resp_en) && $past(acc_par));
  endproperty
  a_parity: assert property (p_parity) else $error("parity capture wrong"); // R08

  property p_no_requeue;
    @(posedge ref_clk) disable iff (srst)
    (acc_valid && data_ok && hit && st.state inside {ST_QUEUED, ST_ATTEMPT})
      |-> rsp == RSP_RETRY ##1 $stable(st.addr) && $stable(st.cmd);
  endproperty
  a_no_requeue: assert property (p_no_requeue) else $error("queued request requeued"); // R12

  property p_deliver;
    @(posedge ref_clk) disable iff (srst)
    served |-> rsp == RSP_COMPLETE && rsp_status == st.status ##1 st.state == ST_IDLE;
  endproperty
  a_deliver: assert property (p_deliver) else $error("completion not delivered"); // R07

  property p_no_drop_attempted;
    @(posedge ref_clk) disable iff (srst)
    (st.state == ST_ATTEMPT && !dst_done) |=> st.state == ST_ATTEMPT && dst_req;
  endproperty
  a_no_drop_attempted: assert property (p_no_drop_attempted) else $error("attempt dropped"); // R15

  property p_complete_store;
    @(posedge ref_clk) disable iff (srst)
    (st.state == ST_ATTEMPT && dst_done)
      |=> st.state == ST_DONE && st.status == $past(dst_status);
  endproperty
  a_complete_store: assert property (p_complete_store) else $error("status not stored"); // R06

  // The age reaches the limit on the drop edge, so it only counts while held
  property p_discard;
    @(posedge ref_clk) disable iff (srst)
    (st.state == ST_DONE) |-> done_age < (`DTT_TMR_W+1)'(DISCARD_CLKS);
  endproperty
  a_discard: assert property (p_discard) else $error("completion held too long"); // R18

  property p_busy_retry;
    @(posedge ref_clk) disable iff (srst)
    (acc_valid && data_ok && is_delayable(acc_cmd) && !hit && st.state != ST_IDLE
     && !droppable) |-> rsp == RSP_RETRY ##1 $stable(st.cmd);
  endproperty
  a_busy_retry: assert property (p_busy_retry) else $error("busy entry not retried"); // R23

  // Only reads that cannot be fetched again are worth an error when dropped
  property p_disc_report;
    @(posedge ref_clk) disable iff (srst)
    (st.state == ST_DONE && expired && !served)
      |=> disc_err == (!$past(st.pref) && $past(st.cmd) inside
                       {`DTT_CMD_IACK, `DTT_CMD_IO_RD, `DTT_CMD_CFG_RD, `DTT_CMD_MEM_RD});
  endproperty
  a_disc_report: assert property (p_disc_report) else $error("discard report wrong"); // R19

  // A busy entry must never hold off a memory write the sink can take
  property p_mw_accept;
    @(posedge ref_clk) disable iff (srst)
    (acc_valid && acc_irdy && is_mem_write(acc_cmd) && pw_ready && st.state != ST_IDLE)
      |-> rsp == RSP_POSTED;
  endproperty
  a_mw_accept: assert property (p_mw_accept) else $error("memory write blocked"); // R21

  // Stored write data keeps enabled lanes and zeroes the rest
  property p_lane_capture;
    @(posedge ref_clk) disable iff (srst)
    ($past(st.state) != ST_QUEUED && st.state == ST_QUEUED && is_dly_write(st.cmd))
      |-> st.wdata == ($past(acc_wdata) & $past(lane_mask));
  endproperty
  a_lane_capture: assert property (p_lane_capture) else $error("write lanes lost"); // R09

  // Only a completion that can be fetched again may give way to a new request
  property p_replace;
    @(posedge ref_clk) disable iff (srst)
    ($past(st.state) == ST_DONE && st.state == ST_QUEUED)
      |-> $past(st.pref) || is_line_read($past(st.cmd));
  endproperty
  a_replace: assert property (p_replace) else $error("completion dropped early"); // R17

  c_posted:  cover property (@(posedge ref_clk) disable iff (srst) rsp == RSP_POSTED);
  c_served:  cover property (@(posedge ref_clk) disable iff (srst) served);
  c_expiry:  cover property (@(posedge ref_clk) disable iff (srst) st.disc_err);
  c_replace: cover property (@(posedge ref_clk) disable iff (srst)
                             droppable && acc_valid && !hit && is_delayable(acc_cmd));
  c_dly_write: cover property (@(posedge ref_clk) disable iff (srst)
                               served && is_dly_write(acc_cmd));

endmodule : dtt_target

`default_nettype wire

// file: bench/dtt_dst_model.sv
/*
  Destination-side model for the delayed transaction target.
  Assumes dst_req stays high until the cycle after dst_done, one attempt at a time.
*/
`default_nettype none
`include "dtt_consts.svh"

module dtt_dst_model
  import dtt_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               stall,
  input  wire logic [7:0]         lat,
  input  wire logic [2:0]         st_in,
  input  wire logic [`DTT_DW-1:0] rd_in,
  input  wire logic               dst_req,
  output logic                    dst_ready,
  output logic                    dst_done,
  output logic [2:0]              dst_status,
  output logic [`DTT_DW-1:0]      dst_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt;
  logic       served;

  // Stall holds the target off before its first attempt
  assign dst_ready = ~stall;

  // Answer lat+1 cycles after the request; status and data toggle outside the done cycle
  // so a late sample by the target never sees a stale but plausible value
  always @(posedge ref_clk) begin
    dst_done   <= 1'b0;
    dst_status <= ~dst_status;
    dst_rdata  <= ~dst_rdata;
    if (srst) begin
      cnt        <= 8'h00;
      served     <= 1'b0;
      dst_status <= 3'h5;
      dst_rdata  <= 32'h5A5A_5A5A;
    end else if (dst_req && !served) begin
      if (cnt == lat) begin
        dst_done   <= 1'b1;
        dst_status <= st_in;
        dst_rdata  <= rd_in;
        served     <= 1'b1;
        cnt        <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end else if (!dst_req) begin
      served <= 1'b0;
    end
  end
endmodule : dtt_dst_model

`default_nettype wire

// file: bench/tb.sv
/*
  Self-checking bench for the delayed transaction target.
  Assumes the destination model beside it and a shortened discard timer of 16 clocks.
*/
`default_nettype none
`include "dtt_consts.svh"

module tb;
  import dtt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0, srst = 1'b1, par_resp_en, acc_valid, acc_irdy, acc_req64, acc_par;
  logic acc_pref, pw_ready, stall, pw_valid, dst_ready, dst_req, dst_req64, dst_done, disc_err;
  logic [3:0]  acc_cmd, acc_be, dst_cmd, dst_be;
  logic [31:0] acc_addr, acc_wdata, rsp_rdata, dst_addr, dst_wdata, dst_rdata, rd_in;
  logic [2:0]  rsp_status, dst_status, st_in;
  logic [7:0]  lat;
  dtt_rsp_e    rsp;
  int          mismatches = 0, samples_checked = 0, disc_cnt = 0, seed;
  logic [3:0]  cmds [8] = '{`DTT_CMD_IACK, `DTT_CMD_IO_RD, `DTT_CMD_IO_WR, `DTT_CMD_CFG_RD,
                            `DTT_CMD_CFG_WR, `DTT_CMD_MEM_RD, `DTT_CMD_MEM_RDL, `DTT_CMD_MEM_RDM};

  always #12.5 ref_clk = ~ref_clk;

  dtt_target #(.DISCARD_CLKS(16)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .par_resp_en(par_resp_en), .acc_valid(acc_valid),
    .acc_irdy(acc_irdy), .acc_cmd(acc_cmd), .acc_addr(acc_addr), .acc_be(acc_be),
    .acc_req64(acc_req64), .acc_par(acc_par), .acc_pref(acc_pref), .acc_wdata(acc_wdata),
    .rsp(rsp), .rsp_status(rsp_status), .rsp_rdata(rsp_rdata), .pw_valid(pw_valid),
    .pw_ready(pw_ready), .dst_ready(dst_ready), .dst_req(dst_req), .dst_cmd(dst_cmd),
    .dst_addr(dst_addr), .dst_be(dst_be), .dst_req64(dst_req64), .dst_wdata(dst_wdata),
    .dst_done(dst_done), .dst_status(dst_status), .dst_rdata(dst_rdata), .disc_err(disc_err));

  dtt_dst_model u_dst (
    .ref_clk(ref_clk), .srst(srst), .stall(stall), .lat(lat), .st_in(st_in), .rd_in(rd_in),
    .dst_req(dst_req), .dst_ready(dst_ready), .dst_done(dst_done), .dst_status(dst_status),
    .dst_rdata(dst_rdata));

  // Discard error pulses are counted so each scenario can compare deltas
  always @(posedge ref_clk) begin
    if (disc_err === 1'b1) disc_cnt <= disc_cnt + 1;
  end

  // ---------------------------------------------------------------------------
  // Expectations and checks
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] exp_rd(input logic [3:0] c, input logic [31:0] r);
    return (c == `DTT_CMD_IO_WR || c == `DTT_CMD_CFG_WR) ? 32'h0000_0000 : r;
  endfunction : exp_rd

  function automatic logic [31:0] lanes(input logic [3:0] b, input logic [31:0] w);
    return w & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction : lanes

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------------
  // Master and destination helpers
  // ---------------------------------------------------------------------------
  // One access held for one clock; the answer is combinational, so look mid-cycle
  task automatic acc(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b,
                     input logic [31:0] w, input logic p, input logic irdy, input dtt_rsp_e e);
    repeat (2) @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_cmd   <= c;
    acc_addr  <= a;
    acc_be    <= b;
    acc_wdata <= w;
    acc_pref  <= p;
    acc_irdy  <= irdy;
    acc_par   <= 1'($random(seed));
    @(negedge ref_clk);
    check(rsp === e, "unexpected answer");
    if (e == RSP_POSTED) check(pw_valid === 1'b1, "posted write not offered");
    @(posedge ref_clk);
    acc_valid <= 1'b0;
  endtask : acc

  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (dst_req !== lvl && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    check(dst_req === lvl, "destination request timing");
  endtask : wait_req

  // Full delayed transfer with awkward traffic while it is outstanding
  task automatic txn(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b,
                     input logic [31:0] w, input logic p, input logic [2:0] s);
    logic [31:0] r;
    r = $random(seed);
    st_in     <= s;
    rd_in     <= r;
    acc_req64 <= 1'($random(seed));
    par_resp_en <= 1'($random(seed));
    if (c == `DTT_CMD_IO_WR || c == `DTT_CMD_CFG_WR) acc(c, a, b, w, p, 1'b0, RSP_NONE);
    acc(c, a, b, w, p, 1'b1, RSP_RETRY);
    acc(c, a, b, w, p, 1'b1, RSP_RETRY);
    acc(c, a + 32'h4, b, w, p, 1'b1, RSP_RETRY);
    acc(`DTT_CMD_MEM_WR, a, b, w, 1'b0, 1'b1, RSP_POSTED);
    wait_req(1'b1);
    check(dst_cmd === c && dst_addr === a && dst_be === b, "captured fields");
    check(dst_req64 === acc_req64, "captured wide flag");
    if (exp_rd(c, 32'h1) == 32'h0) check(lanes(b, dst_wdata) === lanes(b, w), "wdata");
    wait_req(1'b0);
    acc(c, a, (c == `DTT_CMD_MEM_RD) ? ~b : b, w, p, 1'b1, RSP_COMPLETE);
    check(rsp_status === s && rsp_rdata === exp_rd(c, r), "completion contents");
    acc(c, a, b, w, p, 1'b1, RSP_RETRY);
    wait_req(1'b1);
    wait_req(1'b0);
    acc(c, a, b, w, p, 1'b1, RSP_COMPLETE);
  endtask : txn

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] a;
    int          d;
    seed = 78769;
    {par_resp_en, acc_valid, acc_irdy, acc_req64, acc_par, acc_pref, stall} = 7'h00;
    pw_ready = 1'b1;
    {acc_cmd, acc_be} = 8'h00;
    {acc_addr, acc_wdata, rd_in} = '0;
    st_in = 3'h0;
    lat = 8'd30;
    repeat (5) @(posedge ref_clk);
    srst      <= 1'b0;
    par_resp_en <= 1'b1;
    @(negedge ref_clk);
    check(rsp === RSP_NONE && dst_req === 1'b0 && disc_err === 1'b0, "reset state");
    acc(`DTT_CMD_MEM_WRI, 32'h0000_1000, 4'hF, 32'h1234_5678, 1'b0, 1'b1, RSP_POSTED);
    @(posedge ref_clk);
    pw_ready <= 1'b0;
    acc(`DTT_CMD_MEM_WR, 32'h0000_1004, 4'hF, 32'h0, 1'b0, 1'b1, RSP_RETRY);
    check(dst_req === 1'b0, "memory write delayed");
    pw_ready <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      txn(cmds[i], $random(seed), 4'($random(seed)), $random(seed),
          cmds[i] == `DTT_CMD_MEM_RD, 3'(i % 5));
    end
    check(disc_cnt == 0, "spurious discard");
    // Non-prefetchable read left uncollected; queued under stall first
    a = $random(seed);
    stall <= 1'b1;
    acc(`DTT_CMD_IO_RD, a, 4'hF, 32'h0, 1'b0, 1'b1, RSP_RETRY);
    repeat (10) @(negedge ref_clk);
    check(dst_req === 1'b0, "attempt while destination busy");
    @(posedge ref_clk);
    stall <= 1'b0;
    wait_req(1'b1);
    wait_req(1'b0);
    d = disc_cnt;
    repeat (40) @(negedge ref_clk);
    check(disc_cnt == d + 1, "discard error pulse");
    acc(`DTT_CMD_IO_RD, a, 4'hF, 32'h0, 1'b0, 1'b1, RSP_RETRY);
    wait_req(1'b1);
    wait_req(1'b0);
    acc(`DTT_CMD_IO_RD, a, 4'hF, 32'h0, 1'b0, 1'b1, RSP_COMPLETE);
    // A stored line-read completion gives way to a new request
    acc(`DTT_CMD_MEM_RDL, a, 4'hF, 32'h0, 1'b1, 1'b1, RSP_RETRY);
    wait_req(1'b1);
    wait_req(1'b0);
    acc(`DTT_CMD_IO_RD, a + 32'h8, 4'h3, 32'h0, 1'b0, 1'b1, RSP_RETRY);
    wait_req(1'b1);
    check(dst_addr === a + 32'h8, "replacement address");
    wait_req(1'b0);
    acc(`DTT_CMD_IO_RD, a + 32'h8, 4'h3, 32'h0, 1'b0, 1'b1, RSP_COMPLETE);
    // A line-read completion left to expire is dropped without a report
    acc(`DTT_CMD_MEM_RDL, a + 32'hC, 4'hF, 32'h0, 1'b1, 1'b1, RSP_RETRY);
    wait_req(1'b1);
    wait_req(1'b0);
    repeat (40) @(negedge ref_clk);
    acc(`DTT_CMD_MEM_RDL, a + 32'hC, 4'hF, 32'h0, 1'b1, 1'b1, RSP_RETRY);
    check(disc_cnt == d + 1, "error on prefetchable drop");
    final_report();
  end

  // Watchdog: the sequence needs a few thousand clocks at most
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
endmodule : tb

`default_nettype wire
